// *** rtl/plbe_pkg.sv ***
package plbe_pkg;

  // ****************************************************************
  // register location and layout
  // ****************************************************************
  localparam logic [4:0]  REG_ADDR       = 5'h18;
  localparam int          BIT_BAD_SSD    = 15;
  localparam int          BIT_CODEC      = 14;
  localparam int          BIT_SCRAM      = 13;
  localparam int          BIT_ALIGN      = 12;
  localparam int          BIT_MANCH_LOOP = 11;
  localparam int          BIT_FIBER_DRV  = 10;
  localparam int          BIT_REMOTE     = 9;
  localparam int          BIT_MEDIUM     = 8;
  localparam int          BIT_STRIP      = 7;
  localparam int          BIT_FDX_CRS    = 6;
  localparam int          BIT_LB_TX_DIS  = 5;
  localparam int          BIT_CODE_SEL   = 4;
  localparam int          BIT_PEND_SEL   = 3;
  // fixed reset ones: bits 15 and 5; strap bits are or-ed in
  localparam logic [15:0] REG_RST_VAL    = 16'h8020;

  // ****************************************************************
  // values shown on the receive data lines
  // ****************************************************************
  localparam logic [3:0]  RXD_FALSE_CARR = 4'he;
  localparam logic [4:0]  RXD5_FALSE_CAR = 5'h1e;
  localparam logic [3:0]  RXD_CODE_ALT   = 4'h5;
  localparam logic [3:0]  RXD_CODE_DEF   = 4'h6;
  localparam logic [3:0]  RXD_PEND_ALT   = 4'h4;
  localparam logic [3:0]  RXD_PEND_DEF   = 4'h6;
  localparam logic [3:0]  RXD_LINK_ERR   = 4'h3;
  localparam logic [3:0]  RXD_PKT_ERR    = 4'h2;

  // ****************************************************************
  // receive symbol stream
  // ****************************************************************
  localparam logic [4:0]  SYM_IDLE       = 5'h1f;
  localparam logic [4:0]  SYM_J          = 5'h18;
  localparam logic [4:0]  SYM_T          = 5'h0d;
  localparam logic [1:0]  PEND_IDLES     = 2'h2;
  localparam logic [3:0]  PREAMBLE_NIBS  = 4'he;

  // ****************************************************************
  // management frame
  // ****************************************************************
  localparam logic [1:0]  OP_READ        = 2'h2;
  localparam logic [1:0]  OP_WRITE       = 2'h1;
  localparam logic [4:0]  HDR_LAST       = 5'h0b;
  localparam logic [4:0]  DATA_LAST      = 5'h0f;

endpackage : plbe_pkg

// *** rtl/plbe_cfg_if.sv ***
`timescale 1ns/10ps
// configuration bits handed from the register and the report enable pins to the receive reporter
interface plbe_cfg_if;
  logic false_carrier_en;
  logic align_bypass;
  logic codec_bypass;
  logic code_sel;
  logic pend_sel;
  logic code_en;
  logic link_en;
  logic pkt_en;
  logic strip_en;

  modport src (output false_carrier_en, align_bypass, codec_bypass, code_sel,
               pend_sel, code_en, link_en, pkt_en, strip_en);
  modport dst (input  false_carrier_en, align_bypass, codec_bypass, code_sel,
               pend_sel, code_en, link_en, pkt_en, strip_en);
endinterface : plbe_cfg_if

// *** rtl/plbe_rx_report.sv ***
`timescale 1ns/10ps
module plbe_rx_report (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  plbe_cfg_if.dst         cfg,
  input  wire logic [4:0] rxd_in,
  input  wire logic       rx_dv_in,
  input  wire logic       sym_vld,
  input  wire logic [4:0] sym,
  input  wire logic       bad_ssd_evt,
  input  wire logic       code_err_evt,
  input  wire logic       link_err_evt,
  input  wire logic       pkt_err_evt,
  output logic [4:0]      mii_rxd_q,
  output logic            mii_rx_dv_q,
  output logic            mii_rx_er_q
);

  logic       in_frame_q;
  logic [1:0] idle_cnt_q;
  logic       pend_evt;
  logic [3:0] nib_cnt_q;
  logic       strip_now;

  // ****************************************************************
  // premature end: two idles inside a frame before the end delimiter
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      in_frame_q <= 1'b0;
      idle_cnt_q <= 2'h0;
    end else if (sym_vld) begin
      if (sym == plbe_pkg::SYM_J) begin
        in_frame_q <= 1'b1;
        idle_cnt_q <= 2'h0;
      end else if (sym == plbe_pkg::SYM_T || pend_evt) begin
        in_frame_q <= 1'b0;
        idle_cnt_q <= 2'h0;
      end else if (in_frame_q && sym == plbe_pkg::SYM_IDLE) begin
        idle_cnt_q <= idle_cnt_q + 2'h1;
      end else begin
        idle_cnt_q <= 2'h0;
      end
    end
  end

  // second idle in a row ends the frame with an error
  assign pend_evt = sym_vld && in_frame_q && sym == plbe_pkg::SYM_IDLE &&
                    idle_cnt_q == plbe_pkg::PEND_IDLES - 2'h1;

  // ****************************************************************
  // preamble strip: hide the first fourteen nibbles of each frame
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !rx_dv_in) begin
      nib_cnt_q <= 4'h0;
    end else if (nib_cnt_q != plbe_pkg::PREAMBLE_NIBS) begin
      nib_cnt_q <= nib_cnt_q + 4'h1;
    end
  end

  assign strip_now = cfg.strip_en && nib_cnt_q != plbe_pkg::PREAMBLE_NIBS;

  // ****************************************************************
  // mii receive output: error reports override frame data
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mii_rxd_q   <= 5'h00;
      mii_rx_dv_q <= 1'b0;
      mii_rx_er_q <= 1'b0;
    end else if (bad_ssd_evt && cfg.false_carrier_en && !cfg.align_bypass) begin
      mii_rx_dv_q <= 1'b0;
      mii_rx_er_q <= 1'b1;
      // five-bit mode puts 11110 on all five lines; rx_er is raised as well
      mii_rxd_q   <= cfg.codec_bypass ? plbe_pkg::RXD5_FALSE_CAR
                                      : {1'b1, plbe_pkg::RXD_FALSE_CARR};
    end else if (pend_evt) begin
      mii_rx_dv_q <= 1'b0;
      mii_rx_er_q <= 1'b1;
      mii_rxd_q   <= {1'b1, cfg.pend_sel ? plbe_pkg::RXD_PEND_ALT
                                         : plbe_pkg::RXD_PEND_DEF};
    end else if (code_err_evt && cfg.code_en) begin
      mii_rx_dv_q <= rx_dv_in;
      mii_rx_er_q <= 1'b1;
      // the select bit only counts once the enable lets the report out
      mii_rxd_q   <= {1'b1, cfg.code_sel ? plbe_pkg::RXD_CODE_ALT
                                         : plbe_pkg::RXD_CODE_DEF};
    end else if (link_err_evt && cfg.link_en) begin
      mii_rx_dv_q <= 1'b0;
      mii_rx_er_q <= 1'b1;
      mii_rxd_q   <= {1'b1, plbe_pkg::RXD_LINK_ERR};
    end else if (pkt_err_evt && cfg.pkt_en) begin
      mii_rx_dv_q <= rx_dv_in;
      mii_rx_er_q <= 1'b1;
      mii_rxd_q   <= {1'b1, plbe_pkg::RXD_PKT_ERR};
    end else begin
      mii_rx_dv_q <= rx_dv_in && !strip_now;
      mii_rx_er_q <= 1'b0;
      mii_rxd_q   <= rxd_in;
    end
  end

endmodule : plbe_rx_report

// *** rtl/plbe_top.sv ***
`timescale 1ns/10ps
// How it works
// - bit 15 set: false carrier shows rx_er high, rx_dv low, rxd 1110
// - five-bit mode false carrier: rx_dv low, five lines show 11110
// - alignment bypassed: no carrier detect, never report false carrier
// - bit 14, strapped at reset, bypasses block decoder and encoder
// - bit 13, strapped, bypasses scrambling; fiber nrzi data accepted
// - bit 12, strapped, bypasses descrambling, alignment, coding, scrambling
// - bit 11 loops manchester encoder output into the decoder
// - bit 10 picks fiber driver strength: clear 50 ohm, set 150 ohm
// - bit 9 returns line data to line, shows it on mii, ignores tx
// - remote and medium loopback both set: neither loop is entered
// - bit 8 feeds scrambled nrzi transmit data into descrambler input
// - bit 7 strips the seven preamble bytes, frame starts with sfd
// - legacy mode ignores writes to bit 7 and disables stripping
// - full duplex: bit 6 picks transmit or receive as carrier source
// - bit 5 keeps medium or manchester loopback data off the line
// - code error enable overrides bit 4, which acts only when enabled
// - premature end: rx_er with 4h when bit 3 set, else 6h
// - two idles inside a frame before end delimiter mean premature end
// - link error report enable: rx_er with 3h, else not reported
// - packet error report enable: rx_er with 2h, else not reported
// - code error report enable governs whether code errors are reported
module plbe_top (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // management serial port
  input  wire logic       mdc,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe,
  input  wire logic [4:0] phy_addr,
  // strap pins
  input  wire logic       strap_skip_block_codec,
  input  wire logic       strap_skip_scrambling,
  input  wire logic       strap_skip_alignment,
  // neighbouring configuration bits
  input  wire logic       compat_mode,
  input  wire logic       link_err_report_en,
  input  wire logic       pkt_err_report_en,
  input  wire logic       code_err_report_en,
  // carrier sense sources
  input  wire logic       full_duplex,
  input  wire logic       tx_active,
  input  wire logic       rx_active,
  output logic            crs_q,
  // 100 Mb/s nrzi path
  input  wire logic       tx_nrzi,
  input  wire logic       line_nrzi,
  input  wire logic       fiber_nrzi,
  output logic            descr_nrzi_q,
  // 10 Mb/s manchester path
  input  wire logic       manch_enc,
  input  wire logic       line_manch,
  output logic            manch_dec_q,
  // mii transmit toward the line
  input  wire logic [3:0] mii_txd,
  input  wire logic       mii_tx_en,
  output logic [3:0]      line_txd_q,
  output logic            line_tx_en_q,
  // receive stream and events from the decoder
  input  wire logic [4:0] rxd_in,
  input  wire logic       rx_dv_in,
  input  wire logic       sym_vld,
  input  wire logic [4:0] sym,
  input  wire logic       bad_ssd_evt,
  input  wire logic       code_err_evt,
  input  wire logic       link_err_evt,
  input  wire logic       pkt_err_evt,
  output logic [4:0]      mii_rxd_q,
  output logic            mii_rx_dv_q,
  output logic            mii_rx_er_q,
  // static controls to the datapath
  output logic            codec_bypass_q,
  output logic            scram_bypass_q,
  output logic            align_bypass_q,
  output logic            fiber_driver_strength_q,
  output logic            mii_tx_ignore_q
);

  typedef enum logic [2:0] {
    MD_IDLE,
    MD_START,
    MD_HDR,
    MD_TA,
    MD_DATA
  } plbe_mdio_st_t;

  plbe_mdio_st_t st_q;
  logic [15:0]   cfg_q;
  logic [2:0]    strap_s1_q;
  logic [2:0]    strap_s2_q;
  logic [4:0]    addr_s1_q;
  logic [4:0]    addr_s2_q;
  logic          mdc_s1_q;
  logic          mdc_s2_q;
  logic          mdc_s3_q;
  logic          mdio_s1_q;
  logic          mdio_s2_q;
  logic          mdc_rise;
  logic [4:0]    cnt_q;
  logic [10:0]   hdr_q;
  logic [11:0]   hdr_full;
  logic          rd_q;
  logic          hit_q;
  logic [15:0]   shift_q;
  logic [15:0]   rd_val;
  logic [15:0]   wr_val;
  logic [15:0]   rst_val;
  logic          remote_eff;
  logic          medium_eff;
  logic          manch_loop;
  logic          loop_tx_block;

  plbe_cfg_if cfg_bus ();

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // first stage is only read by the second; the third mdc flop is for
  // edge finding and looks at the stable copy only
  always_ff @(posedge sys_clk) begin
    strap_s1_q <= {strap_skip_block_codec, strap_skip_scrambling, strap_skip_alignment};
    strap_s2_q <= strap_s1_q;
    addr_s1_q  <= phy_addr;
    addr_s2_q  <= addr_s1_q;
    mdc_s1_q   <= mdc;
    mdc_s2_q   <= mdc_s1_q;
    mdc_s3_q   <= mdc_s2_q;
    mdio_s1_q  <= mdio_i;
    mdio_s2_q  <= mdio_s1_q;
  end

  assign mdc_rise = mdc_s2_q && !mdc_s3_q;

  // ****************************************************************
  // management frame decode
  // ****************************************************************
  assign hdr_full = {hdr_q, mdio_s2_q};

  // frame state, bit counter and header capture
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q  <= MD_IDLE;
      cnt_q <= 5'h00;
      hdr_q <= 11'h000;
      rd_q  <= 1'b0;
      hit_q <= 1'b0;
    end else if (mdc_rise) begin
      unique case (st_q)
        MD_IDLE: begin
          // preamble is optional: any zero after ones opens a frame
          if (!mdio_s2_q) begin
            st_q <= MD_START;
          end
        end
        MD_START: begin
          st_q  <= mdio_s2_q ? MD_HDR : MD_IDLE;
          cnt_q <= 5'h00;
        end
        MD_HDR: begin
          hdr_q <= hdr_full[10:0];
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == plbe_pkg::HDR_LAST) begin
            st_q  <= MD_TA;
            cnt_q <= 5'h00;
            rd_q  <= hdr_full[11:10] == plbe_pkg::OP_READ;
            hit_q <= hdr_full[9:5] == addr_s2_q && hdr_full[4:0] == plbe_pkg::REG_ADDR &&
                     (hdr_full[11:10] == plbe_pkg::OP_READ ||
                      hdr_full[11:10] == plbe_pkg::OP_WRITE);
          end
        end
        MD_TA: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q != 5'h00) begin
            st_q  <= MD_DATA;
            cnt_q <= 5'h00;
          end
        end
        MD_DATA: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == plbe_pkg::DATA_LAST) begin
            st_q <= MD_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // read shifter and mdio drive
  // ****************************************************************
  // legacy mode shows the strip bit as zero, matching its effect
  assign rd_val = compat_mode ? (cfg_q & ~(16'h0001 << plbe_pkg::BIT_STRIP)) : cfg_q;

  // the pin changes right after the detected rising edge, giving the
  // station a whole mdc period before it samples
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mdio_o  <= 1'b0;
      mdio_oe <= 1'b0;
      shift_q <= 16'h0000;
    end else if (mdc_rise) begin
      if (st_q == MD_TA && rd_q && hit_q) begin
        if (cnt_q == 5'h00) begin
          mdio_oe <= 1'b1;
          mdio_o  <= 1'b0;
        end else begin
          mdio_o  <= rd_val[15];
          shift_q <= {rd_val[14:0], 1'b0};
        end
      end else if (st_q == MD_DATA && rd_q && hit_q) begin
        if (cnt_q == plbe_pkg::DATA_LAST) begin
          mdio_oe <= 1'b0;
          mdio_o  <= 1'b0;
        end else begin
          mdio_o  <= shift_q[15];
          shift_q <= {shift_q[14:0], 1'b0};
        end
      end else if (st_q == MD_DATA && !rd_q) begin
        shift_q <= {shift_q[14:0], mdio_s2_q};
      end else begin
        mdio_oe <= 1'b0;
        mdio_o  <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // configuration register
  // ****************************************************************
  assign rst_val = plbe_pkg::REG_RST_VAL |
                   ({15'h0000, strap_s2_q[2]} << plbe_pkg::BIT_CODEC) |
                   ({15'h0000, strap_s2_q[1]} << plbe_pkg::BIT_SCRAM) |
                   ({15'h0000, strap_s2_q[0]} << plbe_pkg::BIT_ALIGN);

  // in legacy mode the strip bit keeps its stored value on a write
  always_comb begin
    wr_val = {shift_q[14:0], mdio_s2_q};
    if (compat_mode) begin
      wr_val[plbe_pkg::BIT_STRIP] = cfg_q[plbe_pkg::BIT_STRIP];
    end
  end

  // straps are sampled every cycle of reset, so hold reset for three
  // edges to let the pins pass the synchroniser first
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_q <= rst_val;
    end else if (mdc_rise && st_q == MD_DATA && !rd_q && hit_q &&
                 cnt_q == plbe_pkg::DATA_LAST) begin
      cfg_q <= wr_val;
    end
  end

  // ****************************************************************
  // effective loop selections
  // ****************************************************************
  // both loops set is a software fault; entering neither is the safe way
  assign remote_eff    = cfg_q[plbe_pkg::BIT_REMOTE] && !cfg_q[plbe_pkg::BIT_MEDIUM];
  assign medium_eff    = cfg_q[plbe_pkg::BIT_MEDIUM] && !cfg_q[plbe_pkg::BIT_REMOTE];
  assign manch_loop    = cfg_q[plbe_pkg::BIT_MANCH_LOOP];
  assign loop_tx_block = cfg_q[plbe_pkg::BIT_LB_TX_DIS] && (medium_eff || manch_loop);

  // ****************************************************************
  // static controls to the datapath
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      codec_bypass_q          <= 1'b0;
      scram_bypass_q          <= 1'b0;
      align_bypass_q          <= 1'b0;
      fiber_driver_strength_q <= 1'b0;
      mii_tx_ignore_q         <= 1'b0;
    end else begin
      // alignment bypass takes the coder and scrambler with it
      codec_bypass_q          <= cfg_q[plbe_pkg::BIT_CODEC] ||
                                 cfg_q[plbe_pkg::BIT_ALIGN];
      scram_bypass_q          <= cfg_q[plbe_pkg::BIT_SCRAM] ||
                                 cfg_q[plbe_pkg::BIT_ALIGN];
      align_bypass_q          <= cfg_q[plbe_pkg::BIT_ALIGN];
      fiber_driver_strength_q <= cfg_q[plbe_pkg::BIT_FIBER_DRV];
      mii_tx_ignore_q         <= remote_eff;
    end
  end

  // ****************************************************************
  // loopback muxes
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      descr_nrzi_q <= 1'b0;
      manch_dec_q  <= 1'b0;
    end else begin
      if (medium_eff) begin
        descr_nrzi_q <= tx_nrzi;
      end else if (cfg_q[plbe_pkg::BIT_SCRAM]) begin
        descr_nrzi_q <= fiber_nrzi;
      end else begin
        descr_nrzi_q <= line_nrzi;
      end
      manch_dec_q <= manch_loop ? manch_enc : line_manch;
    end
  end

  // line transmit: remote loop resends received data, mii tx is dropped
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      line_txd_q   <= 4'h0;
      line_tx_en_q <= 1'b0;
    end else if (remote_eff) begin
      line_txd_q   <= rxd_in[3:0];
      line_tx_en_q <= rx_dv_in;
    end else begin
      line_txd_q   <= mii_txd;
      line_tx_en_q <= mii_tx_en && !loop_tx_block;
    end
  end

  // ****************************************************************
  // carrier sense
  // ****************************************************************
  // the source choice only matters in full duplex
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      crs_q <= 1'b0;
    end else if (full_duplex) begin
      crs_q <= cfg_q[plbe_pkg::BIT_FDX_CRS] ? tx_active : rx_active;
    end else begin
      crs_q <= tx_active || rx_active;
    end
  end

  // ****************************************************************
  // receive error reporting
  // ****************************************************************
  assign cfg_bus.false_carrier_en = cfg_q[plbe_pkg::BIT_BAD_SSD];
  assign cfg_bus.align_bypass     = cfg_q[plbe_pkg::BIT_ALIGN];
  assign cfg_bus.codec_bypass     = cfg_q[plbe_pkg::BIT_CODEC] || cfg_q[plbe_pkg::BIT_ALIGN];
  assign cfg_bus.code_sel         = cfg_q[plbe_pkg::BIT_CODE_SEL];
  assign cfg_bus.pend_sel         = cfg_q[plbe_pkg::BIT_PEND_SEL];
  assign cfg_bus.code_en          = code_err_report_en;
  assign cfg_bus.link_en          = link_err_report_en;
  assign cfg_bus.pkt_en           = pkt_err_report_en;
  assign cfg_bus.strip_en         = cfg_q[plbe_pkg::BIT_STRIP] && !compat_mode;

  plbe_rx_report u_rx_report (
    .sys_clk      (sys_clk),
    .sys_rst      (sys_rst),
    .cfg          (cfg_bus),
    .rxd_in       (rxd_in),
    .rx_dv_in     (rx_dv_in),
    .sym_vld      (sym_vld),
    .sym          (sym),
    .bad_ssd_evt  (bad_ssd_evt),
    .code_err_evt (code_err_evt),
    .link_err_evt (link_err_evt),
    .pkt_err_evt  (pkt_err_evt),
    .mii_rxd_q    (mii_rxd_q),
    .mii_rx_dv_q  (mii_rx_dv_q),
    .mii_rx_er_q  (mii_rx_er_q)
  );

endmodule : plbe_top

// *** tb/plbe_mac_model.sv ***
`timescale 1ns/10ps
// ****************
// mac transmit side
// ****************
module plbe_mac_model (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic send,
  output logic [3:0] mii_txd,
  output logic       mii_tx_en
);
  // counting nibbles; idle data flips each cycle so a stale value is never trusted
  always_ff @(posedge sys_clk) begin
    mii_tx_en <= send && !sys_rst;
    mii_txd   <= sys_rst ? 4'h0 : (send ? mii_txd + 4'h1 : ~mii_txd);
  end
endmodule : plbe_mac_model

// *** tb/plbe_chk.sv ***
`timescale 1ns/10ps
// ****************
// receive report checks
// ****************
module plbe_chk (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       link_err_report_en,
  input wire logic       pkt_err_report_en,
  input wire logic       code_err_report_en,
  input wire logic       sym_vld,
  input wire logic [4:0] sym,
  input wire logic       bad_ssd_evt,
  input wire logic       code_err_evt,
  input wire logic       link_err_evt,
  input wire logic       pkt_err_evt,
  input wire logic [4:0] mii_rxd_q,
  input wire logic       mii_rx_dv_q,
  input wire logic       mii_rx_er_q,
  input wire logic       align_bypass_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // nb: no symbol and no false carrier, so lower-priority errors can show
  logic nb;
  assign nb = !sym_vld && !bad_ssd_evt;
  sequence s_pend;
    sym_vld && sym == plbe_pkg::SYM_J ##1 sym_vld && sym == plbe_pkg::SYM_IDLE
    ##1 sym_vld && sym == plbe_pkg::SYM_IDLE && !bad_ssd_evt;
  endsequence
  // control lags the register by one cycle, so look at it after the event
  sequence s_fc_byp;
    bad_ssd_evt && !sym_vld && !code_err_evt && !link_err_evt && !pkt_err_evt ##1 align_bypass_q;
  endsequence
  property p_fc;
    !sym_vld && bad_ssd_evt && !align_bypass_q
    |=> !mii_rx_er_q || {mii_rx_dv_q, mii_rxd_q} == 6'h1e;
  endproperty
  a_fc: assert property (p_fc) else $error("false carrier pattern wrong");
  property p_fc_byp;
    s_fc_byp |-> !mii_rx_er_q;
  endproperty
  a_fc_byp: assert property (p_fc_byp) else $error("false carrier while bypassed");
  property p_pend;
    s_pend |=> mii_rx_er_q && !mii_rx_dv_q && mii_rxd_q inside {5'h14, 5'h16};
  endproperty
  a_pend: assert property (p_pend) else $error("premature end missed");
  property p_code;
    nb && code_err_evt && code_err_report_en |=> mii_rx_er_q && mii_rxd_q inside {5'h15, 5'h16};
  endproperty
  a_code: assert property (p_code) else $error("code error value wrong");
  property p_code_off;
    nb && code_err_evt && !code_err_report_en && !link_err_evt && !pkt_err_evt |=> !mii_rx_er_q;
  endproperty
  a_code_off: assert property (p_code_off) else $error("code error not masked");
  property p_link;
    nb && !code_err_evt && link_err_evt && link_err_report_en
    |=> mii_rx_er_q && !mii_rx_dv_q && mii_rxd_q == 5'h13;
  endproperty
  a_link: assert property (p_link) else $error("link error value wrong");
  property p_link_off;
    nb && !code_err_evt && link_err_evt && !link_err_report_en && !pkt_err_evt |=> !mii_rx_er_q;
  endproperty
  a_link_off: assert property (p_link_off) else $error("link error not masked");
  property p_pkt;
    nb && !code_err_evt && !link_err_evt && pkt_err_evt && pkt_err_report_en
    |=> mii_rx_er_q && mii_rxd_q == 5'h12;
  endproperty
  a_pkt: assert property (p_pkt) else $error("packet error value wrong");
endmodule : plbe_chk
bind plbe_top plbe_chk u_plbe_chk (.*);

// *** tb/tb.sv ***
`timescale 1ns/10ps
// ****************
// bench top
// ****************
module tb;
  localparam logic [4:0] RA = plbe_pkg::REG_ADDR;
  logic sys_clk = '0, sys_rst = '1, mdc = '0, md = '1, send = '1, rx_dv_in = '0, sym_vld = '0;
  logic [4:0] phy_addr = 5'h01, rxd_in = 5'h00, sym = 5'h00, mii_rxd_q;
  logic strap_skip_block_codec = '1, strap_skip_scrambling = '0, strap_skip_alignment = '1;
  logic compat_mode = '0, link_err_report_en = '1, pkt_err_report_en = '1;
  logic code_err_report_en = '1, full_duplex = '1, tx_active = '1, rx_active = '0;
  logic tx_nrzi = '1, line_nrzi = '0, fiber_nrzi = '1, manch_enc = '1, line_manch = '0;
  logic bad_ssd_evt = '0, code_err_evt = '0, link_err_evt = '0, pkt_err_evt = '0;
  logic mdio_o, mdio_oe, crs_q, descr_nrzi_q, manch_dec_q, line_tx_en_q, mii_tx_en;
  logic mii_rx_dv_q, mii_rx_er_q, codec_bypass_q, scram_bypass_q, align_bypass_q;
  logic fiber_driver_strength_q, mii_tx_ignore_q;
  logic [3:0] mii_txd, line_txd_q;
  wire        mdio_i = mdio_oe ? mdio_o : md;  // pull-up level when released
  int         num_errors = 0, checked = 0, cyc = 0;
  always #2 sys_clk = ~sys_clk;
  plbe_top u_plbe_top (.*);
  plbe_mac_model u_plbe_mac_model (.*);
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    checked++;
    if (s !== x) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  // one management frame; mdc stands still outside it
  task automatic mx(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                    output logic [15:0] r);
    logic [32:0] f;
    f = {3'b101, op, phy_addr, ra, 1'b1, op[1], wd};
    r = '0;
    @(negedge sys_clk);
    for (int i = 32; i >= 0; i--) begin
      md = f[i];
      repeat (10) @(negedge sys_clk);
      r = {r[14:0], mdio_i};
      mdc = '1;
      repeat (10) @(negedge sys_clk);
      mdc = '0;
    end
    md = '1;
    repeat (50) @(negedge sys_clk);
  endtask : mx
  task automatic wr(input logic [15:0] d);
    logic [15:0] r;
    mx(plbe_pkg::OP_WRITE, RA, d, r);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] x);
    logic [15:0] r;
    mx(plbe_pkg::OP_READ, a, 16'hffff, r);
    chk(r, x);
  endtask : rd
  // events {false carrier, code, link, packet} for one cycle, report seen a cycle later
  task automatic ev(input logic [3:0] e, input logic [6:0] x);
    @(negedge sys_clk) {bad_ssd_evt, code_err_evt, link_err_evt, pkt_err_evt} = e;
    @(negedge sys_clk) {bad_ssd_evt, code_err_evt, link_err_evt, pkt_err_evt} = 4'h0;
    chk({9'h0, mii_rx_er_q, mii_rx_dv_q, mii_rxd_q}, {9'h0, x});
  endtask : ev
  task automatic report_and_stop;
    $display("TB: errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (10) @(negedge sys_clk);
    sys_rst = '0;
    repeat (3) @(negedge sys_clk);
    chk({13'h0, codec_bypass_q, scram_bypass_q, align_bypass_q}, 16'h7);
    rd(RA, 16'hd020);
    rd(5'h19, 16'hffff);
    wr(16'h8410);
    chk({15'h0, fiber_driver_strength_q}, 16'h1);
    ev(4'h8, 7'h5e);
    ev(4'h6, 7'h55);
    ev(4'h2, 7'h53);
    ev(4'h1, 7'h52);
    {code_err_report_en, link_err_report_en, pkt_err_report_en} = '0;
    ev(4'h7, 7'h00);
    {code_err_report_en, rx_dv_in, rxd_in} = {2'b11, 5'h0a};
    wr(16'h8000);
    ev(4'h4, 7'h76);
    wr(16'h8008);
    @(negedge sys_clk) {sym_vld, sym} = {1'b1, plbe_pkg::SYM_J};
    @(negedge sys_clk) sym = plbe_pkg::SYM_IDLE;
    ev(4'h0, 7'h54);
    sym_vld = '0;
    wr(16'h9000);
    ev(4'h8, 7'h2a);
    wr(16'hc000);
    ev(4'h8, 7'h5e);
    wr(16'h2000);
    chk({15'h0, descr_nrzi_q}, 16'h1);
    wr(16'h8120);
    chk({14'h0, descr_nrzi_q, line_tx_en_q}, 16'h2);
    wr(16'h8840);
    chk({13'h0, crs_q, manch_dec_q, line_tx_en_q}, 16'h7);
    wr(16'h8200);
    chk({10'h0, line_txd_q, line_tx_en_q, mii_tx_ignore_q}, 16'h2b);
    wr(16'h8300);
    chk({14'h0, mii_tx_ignore_q, line_tx_en_q}, 16'h1);
    compat_mode = '1;
    wr(16'h8080);
    rd(RA, 16'h8000);
    compat_mode = '0;
    wr(16'h8080);
    rd(RA, 16'h8080);
    @(negedge sys_clk) rx_dv_in = '0;
    @(negedge sys_clk) rx_dv_in = '1;
    repeat (14) @(negedge sys_clk);
    chk({15'h0, mii_rx_dv_q}, 16'h0);
    @(negedge sys_clk);
    chk({15'h0, mii_rx_dv_q}, 16'h1);
    report_and_stop();
  end
  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      report_and_stop();
    end
  end
endmodule : tb
